// ==== hdl/iob_decoder.sv ====
/*
 * Host-bus slave front end of an isolated input / relay board: base decode,
 * byte register select, change-of-state detection and shared interrupt.
 * Assumes host bus strobes and address arrive asynchronously and are held
 * for several clk_sys cycles per access; straps are static.
 */
`timescale 1ns/1ps
module iob_decoder
  import iob_pkg::*;
#(
  parameter int FILT_CYC = 587500
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] hostAddr,
  input wire logic ioRead_n,
  input wire logic ioWrite_n,
  input wire logic addrEnable,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  input wire logic [BASE_W-1:0] baseStrapInstalled,
  input wire logic [IRQ_N-1:0] interruptLineSelectStrap,
  input wire logic [IN_W-1:0] inputFilterStrap,
  input wire logic [IN_W-1:0] isolatedInputBit,
  output logic [IRQ_N-1:0] irqOut,
  output logic [IRQ_N-1:0] irqOe,
  output logic [3:0] relayOut
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Straps are static but still pins, so they pass the same two flops
  logic [IN_W-1:0] inMeta, inSync;
  logic [ADDR_W-1:0] addrMeta, addrSync;
  logic [2:0] ctlMeta, ctlSync;
  logic [7:0] dataMeta, dataSync;
  logic [BASE_W-1:0] baseMeta, baseSync;
  logic [IRQ_N-1:0] lineMeta, lineSync;
  logic [IN_W-1:0] filtMeta, filtSync;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inMeta <= '0;
      inSync <= '0;
    end else begin
      inMeta <= isolatedInputBit;
      inSync <= inMeta;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addrMeta <= '0;
      addrSync <= '0;
    end else begin
      addrMeta <= hostAddr;
      addrSync <= addrMeta;
    end
  end

  // Strobes reset to their idle high level, so no false access follows reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctlMeta <= 3'h3;
      ctlSync <= 3'h3;
    end else begin
      ctlMeta <= {addrEnable, ioWrite_n, ioRead_n};
      ctlSync <= ctlMeta;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dataMeta <= '0;
      dataSync <= '0;
    end else begin
      dataMeta <= hostDataIn;
      dataSync <= dataMeta;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      baseMeta <= '0;
      baseSync <= '0;
      lineMeta <= '0;
      lineSync <= '0;
      filtMeta <= '0;
      filtSync <= '0;
    end else begin
      baseMeta <= baseStrapInstalled;
      baseSync <= baseMeta;
      lineMeta <= interruptLineSelectStrap;
      lineSync <= lineMeta;
      filtMeta <= inputFilterStrap;
      filtSync <= filtMeta;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  // Installed strap reads as the bit value 0
  wire [BASE_W-1:0] baseAddr = ~baseSync;
  wire baseHit = (addrSync[ADDR_W-1:BASE_LSB] == baseAddr);
  wire procCycle = ~ctlSync[2];
  wire [SEL_W-1:0] regSel = addrSync[SEL_W-1:0];
  wire rdAct = baseHit && procCycle && !ctlSync[0];
  wire wrAct = baseHit && procCycle && !ctlSync[1];
  logic wrPrev;
  wire wrStrobe = wrAct && !wrPrev;

  // One offset decode shared by every write target
  function automatic logic selHit(input logic [SEL_W-1:0] sel, input logic [2:0] ofs);
    return sel == ofs;
  endfunction
  wire relayWrite = wrStrobe && selHit(regSel, OFS_IN0);
  wire enableWrite = wrStrobe && selHit(regSel, OFS_COS_EN);

  // ****************************************
  // Input filter
  // ****************************************
  // Strap passes only its synchroniser, so no register can override it
  logic [IN_W-1:0] inFilt;
  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_filt
      logic [19:0] fcnt;
      logic fval;
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          fcnt <= '0;
          fval <= 1'b0;
        end else if (inSync[gi] == fval) begin
          fcnt <= '0;
        end else if (fcnt == 20'(FILT_CYC - 1)) begin
          fval <= inSync[gi];
          fcnt <= '0;
        end else begin
          fcnt <= fcnt + 1'b1;
        end
      end
      assign inFilt[gi] = filtSync[gi] ? fval : inSync[gi];
    end
  endgenerate

  // ****************************************
  // Change-of-state detection
  // ****************************************
  logic [IN_W-1:0] inPrev;
  logic [7:0] cosEnable, cosStatus;
  logic [3:0] relay;
  logic [7:0] readData;
  wire [IN_W-1:0] inChange = inFilt ^ inPrev;
  logic [GRP_N-1:0] grpChange;
  generate
    for (gi = 0; gi < GRP_N; gi++) begin : g_grp
      assign grpChange[gi] = |inChange[gi*GRP_SZ +: GRP_SZ] & cosEnable[gi];
    end
  endgenerate
  wire cosClear = wrStrobe && selHit(regSel, OFS_COS_CLR);
  // Set wins over clear so no event is lost
  wire [7:0] next_cosStatus = (cosClear ? 8'h00 : cosStatus) | grpChange;

  iob_irq_if irqBus ();
  // Fire on new events; a running pulse is not restarted
  assign irqBus.fire = (|grpChange) && !irqBus.busy;

  iob_irq_pulse u_iob_irq_pulse (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .irq(irqBus)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inPrev <= '0;
      cosStatus <= '0;
    end else begin
      inPrev <= inFilt;
      cosStatus <= next_cosStatus;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPrev <= 1'b0;
      hostDataOut <= '0;
    end else begin
      wrPrev <= wrAct;
      hostDataOut <= readData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      relay <= RELAY_RST;
    end else if (relayWrite) begin
      relay <= dataSync[3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cosEnable <= COS_EN_RST;
    end else if (enableWrite) begin
      cosEnable <= dataSync;
    end
  end

  // ****************************************
  // Read mux and outputs
  // ****************************************
  always_comb begin
    readData = 8'h00;
    if (regSel == OFS_IN0) begin
      readData = inFilt[7:0];
    end else if (regSel == OFS_IN1) begin
      readData = inFilt[15:8];
    end else if (regSel == OFS_IN2) begin
      readData = inFilt[23:16];
    end else if (regSel == OFS_IN3) begin
      readData = inFilt[31:24];
    end else if (regSel == OFS_COS_CLR) begin
      readData = cosStatus;
    end
  end

  assign hostDataOe = rdAct;
  assign relayOut = relay;
  assign irqOe = irqBus.drive ? lineSync : '0;
  assign irqOut = irqBus.level ? lineSync : '0;

endmodule

// ==== hdl/iob_pkg.sv ====
/*
 * Constants for the I/O base decoder block: register offsets, field widths,
 * interrupt pulse timing and reset values.
 * Assumes a single 125 MHz system clock; shared by all design files except iob_irq_if.
 */
package iob_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int IRQ_LOW_NS = 750;
  localparam int IRQ_HIGH_NS = 250;
  // Least times round up to whole cycles
  localparam int IRQ_LOW_CYC = (IRQ_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IRQ_HIGH_CYC = (IRQ_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IRQ_CNT_W = 8;

  // ****************************************
  // Address layout
  // ****************************************
  localparam int BASE_LSB = 3;
  localparam int BASE_W = 7;
  localparam int SEL_W = 3;
  localparam int ADDR_W = 10;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] OFS_IN0 = 3'h0;
  localparam logic [2:0] OFS_IN1 = 3'h1;
  localparam logic [2:0] OFS_IN2 = 3'h2;
  localparam logic [2:0] OFS_IN3 = 3'h3;
  localparam logic [2:0] OFS_COS_EN = 3'h4;
  localparam logic [2:0] OFS_COS_CLR = 3'h5;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int IN_W = 32;
  localparam int GRP_N = 8;
  localparam int GRP_SZ = 4;
  localparam int IRQ_N = 16;
  localparam logic [3:0] RELAY_RST = 4'hf;
  localparam logic [7:0] COS_EN_RST = 8'h00;

  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_LOW = 2'b01,
    IRQ_HIGH = 2'b10
  } iob_irq_state_t;

endpackage

// ==== hdl/iob_irq_if.sv ====
/*
 * Carrier between the core and its interrupt pulse shaper.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface iob_irq_if;
  logic fire;
  logic busy;
  logic drive;
  logic level;
  modport core (output fire, input busy);
  modport shaper (input fire, output busy, output drive, output level);
endinterface

// ==== hdl/iob_irq_pulse.sv ====
/*
 * Interrupt pulse shaper: on a fire request drives low, then high, then
 * releases the line. Assumes fire is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/1ps
module iob_irq_pulse
  import iob_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  iob_irq_if.shaper irq
);

  iob_irq_state_t state;
  iob_irq_state_t next_state;
  logic [IRQ_CNT_W-1:0] count;
  logic [IRQ_CNT_W-1:0] next_count;
  wire lowDone = (count == IRQ_CNT_W'(IRQ_LOW_CYC - 1));
  wire highDone = (count == IRQ_CNT_W'(IRQ_HIGH_CYC - 1));

  // ****************************************
  // Pulse sequence
  // ****************************************
  always_comb begin
    next_state = state;
    next_count = count + 1'b1;
    case (state)
      IRQ_IDLE: begin
        next_count = '0;
        if (irq.fire) begin
          next_state = IRQ_LOW;
        end
      end
      IRQ_LOW: begin
        if (lowDone) begin
          next_state = IRQ_HIGH;
          next_count = '0;
        end
      end
      IRQ_HIGH: begin
        if (highDone) begin
          next_state = IRQ_IDLE;
          next_count = '0;
        end
      end
      default: begin
        next_state = IRQ_IDLE;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= IRQ_IDLE;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign irq.busy = (state != IRQ_IDLE);
  assign irq.drive = (state != IRQ_IDLE);
  assign irq.level = (state == IRQ_HIGH);

endmodule

// ==== tb/iob_decoder_props.sv ====
/* Checker on decoder ports: read claim, relay write, irq pulse.
   Assumes one clk_sys domain; bound below. */
`timescale 1ns/1ps
module iob_decoder_props
  import iob_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] hostAddr,
  input wire logic ioRead_n,
  input wire logic ioWrite_n,
  input wire logic addrEnable,
  input wire logic hostDataOe,
  input wire logic [BASE_W-1:0] baseStrapInstalled,
  input wire logic [IRQ_N-1:0] interruptLineSelectStrap,
  input wire logic [IRQ_N-1:0] irqOut,
  input wire logic [IRQ_N-1:0] irqOe,
  input wire logic [3:0] relayOut
);
  // *****
  // Pulse age counter
  // *****
  logic [7:0] cnt;
  wire logic on = |irqOe;
  wire logic hit = hostAddr[9:3] == ~baseStrapInstalled;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt <= 8'h00;
    else cnt <= on ? cnt + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Pins reach the read decode through two flops
  AST_OE_READ: assert property (hostDataOe |-> !$past(ioRead_n, 2))
    else $error("read enable without read strobe");
  AST_OE_HIT: assert property (hostDataOe |-> $past(hit, 2))
    else $error("read enable on address miss");
  AST_OE_CPU: assert property (hostDataOe |-> !$past(addrEnable, 2))
    else $error("read enable on dma cycle");
  AST_OE_RISE: assert property ((!ioRead_n && !addrEnable && hit) [*4] |=> hostDataOe)
    else $error("read hit not claimed");
  AST_RELAY_SRC: assert property ($changed(relayOut) |->
    $past(!ioWrite_n && hit && hostAddr[2:0] == 3'h0 && !addrEnable, 3))
    else $error("relay changed without offset 0 write");
  AST_IRQ_LINE: assert property ((irqOe & ~interruptLineSelectStrap) == 16'h0000)
    else $error("irq driven on unselected line");
  AST_IRQ_LOW: assert property (on && cnt < 8'h5e |-> (irqOut & irqOe) == 16'h0000)
    else $error("irq not low in first phase");
  AST_IRQ_HIGH: assert property (on && cnt >= 8'h5e |-> (irqOut & irqOe) == irqOe)
    else $error("irq not high in second phase");
  AST_IRQ_LEN: assert property (on |-> cnt < 8'h7e)
    else $error("irq driven too long");
  AST_IRQ_END: assert property ($fell(on) |-> $past(cnt) == 8'h7d)
    else $error("irq released early");
  cover property ($rose(hostDataOe));
  cover property ($rose(on));
  cover property ($changed(relayOut));
endmodule
bind iob_decoder iob_decoder_props u_iob_decoder_props (.clk_sys, .rst_n, .hostAddr,
  .ioRead_n, .ioWrite_n, .addrEnable, .hostDataOe, .baseStrapInstalled,
  .interruptLineSelectStrap, .irqOut, .irqOe, .relayOut);

// ==== tb/iob_host_model.sv ====
/* Host processor model: byte I/O cycles with fixed strobe lengths.
   Assumes the caller enters just after a clk_sys rising edge. */
`timescale 1ns/1ps
module iob_host_model
  import iob_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe,
  output logic [ADDR_W-1:0] hostAddr,
  output logic ioRead_n,
  output logic ioWrite_n,
  output logic addrEnable,
  output logic [7:0] hostDataIn
);
  initial begin
    hostAddr = 10'h000;
    ioRead_n = 1'b1;
    ioWrite_n = 1'b1;
    addrEnable = 1'b0;
    hostDataIn = 8'h00;
  end
  // Caller keeps base in 100-3ff, clear of other functions
  task automatic cyc(input logic wr, input logic [9:0] a, input logic [7:0] d,
    input logic dma, output logic [7:0] q, output logic oe);
    hostAddr = a;
    addrEnable = dma;
    hostDataIn = d;
    ioWrite_n = !wr;
    ioRead_n = wr;
    oe = 1'b0;
    repeat (6) begin
      @(posedge clk_sys);
      #1;
      oe = oe | hostDataOe;
    end
    q = hostDataOut;
    ioRead_n = 1'b1;
    ioWrite_n = 1'b1;
    // Released data must not look like a held value
    hostDataIn = ~d;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
endmodule

// ==== tb/tb_top.sv ====
/* Testbench for the decoder: reads, refusals, relay, change of state.
   Assumes the host model sits on the bus side. */
`timescale 1ns/1ps
module tb_top;
  import iob_pkg::*;
  localparam logic [9:0] BASE = 10'h300;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [IN_W-1:0] isolatedInputBit = 32'ha5c3_3c5a;
  logic [ADDR_W-1:0] hostAddr;
  logic ioRead_n, ioWrite_n, addrEnable, hostDataOe, oe;
  logic [7:0] hostDataIn, hostDataOut, q;
  logic [IRQ_N-1:0] irqOut, irqOe, seen;
  logic [3:0] relayOut;
  int errorCnt = 0;
  int checked = 0;
  always #4 clk_sys = ~clk_sys;
  iob_decoder #(.FILT_CYC(4)) u_iob_decoder (.clk_sys, .rst_n, .hostAddr, .ioRead_n,
    .ioWrite_n, .addrEnable, .hostDataIn, .hostDataOut, .hostDataOe,
    .baseStrapInstalled(~BASE[9:3]),
    .interruptLineSelectStrap(16'h0020), .inputFilterStrap(32'h0000_0002),
    .isolatedInputBit, .irqOut, .irqOe, .relayOut);
  iob_host_model u_iob_host_model (.clk_sys, .hostDataOut, .hostDataOe, .hostAddr,
    .ioRead_n, .ioWrite_n, .addrEnable, .hostDataIn);
  // *****
  // Shared tasks
  // *****
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic io(logic wr, logic [9:0] a, logic [7:0] d, logic dma = 1'b0);
    u_iob_host_model.cyc(wr, a, d, dma, q, oe);
  endtask
  task automatic closeOut();
    $display("checks %0d errors %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_inputs();
    for (int i = 0; i < 4; i++) begin
      io(1'b0, BASE + 10'(i), 8'h00);
      chk("inByte", {24'h0, isolatedInputBit[8*i+:8]}, {24'h0, q});
      chk("readOe", 32'h1, {31'h0, oe});
    end
    $display("test inputs done");
  endtask
  task automatic t_refuse();
    io(1'b0, BASE + 10'h008, 8'h00);
    chk("missOe", 32'h0, {31'h0, oe});
    io(1'b0, BASE, 8'h00, 1'b1);
    chk("dmaOe", 32'h0, {31'h0, oe});
    io(1'b1, BASE, 8'h00, 1'b1);
    io(1'b1, BASE + 10'h001, 8'h00);
    chk("relayKept", 32'hf, {28'h0, relayOut});
    io(1'b1, BASE, 8'hf5);
    chk("relayWrite", 32'h5, {28'h0, relayOut});
    $display("test refuse done");
  endtask
  task automatic t_filter();
    logic [7:0] prev;
    prev = isolatedInputBit[7:0];
    isolatedInputBit[1:0] = ~isolatedInputBit[1:0];
    io(1'b0, BASE, 8'h00);
    chk("filtSlow", {24'h0, prev[7:2], prev[1], ~prev[0]}, {24'h0, q});
    io(1'b0, BASE, 8'h00);
    chk("filtDone", {24'h0, isolatedInputBit[7:0]}, {24'h0, q});
    $display("test filter done");
  endtask
  task automatic t_cos();
    int lowN = 0;
    int highN = 0;
    io(1'b1, BASE + 10'h004, 8'h01);
    io(1'b1, BASE + 10'h005, 8'h00);
    isolatedInputBit[4] = ~isolatedInputBit[4];
    io(1'b0, BASE + 10'h005, 8'h00);
    chk("cosOff", 32'h0, {24'h0, q});
    isolatedInputBit[0] = ~isolatedInputBit[0];
    seen = 16'h0000;
    repeat (150) begin
      @(posedge clk_sys);
      #1;
      seen = seen | irqOe;
      if (irqOe != 16'h0000 && irqOut == 16'h0000) lowN++;
      if (irqOe != 16'h0000 && irqOut == irqOe) highN++;
    end
    chk("irqLine", 32'h20, {16'h0, seen});
    chk("irqLowCyc", IRQ_LOW_CYC, lowN);
    chk("irqHighCyc", IRQ_HIGH_CYC, highN);
    chk("irqDone", 32'h0, {16'h0, irqOe});
    io(1'b0, BASE + 10'h005, 8'h00);
    chk("cosSet", 32'h1, {24'h0, q});
    io(1'b1, BASE + 10'h005, 8'h5a);
    io(1'b0, BASE + 10'h005, 8'h00);
    chk("cosClr", 32'h0, {24'h0, q});
    $display("test cos done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk("relayRst", 32'hf, {28'h0, relayOut});
    // Let the pin synchronisers and the filtered channel settle first
    repeat (8) @(posedge clk_sys);
    #1;
    t_inputs();
    t_filter();
    t_refuse();
    t_cos();
    closeOut();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    errorCnt++;
    closeOut();
  end
endmodule
